// ==== common/adsp_regs.svh ====
// Character codes and field sizes of the drive serial protocol engine
`ifndef ADSP_REGS_SVH
`define ADSP_REGS_SVH
`define ADSP_CH_EOT 7'h04
`define ADSP_CH_ENQ 7'h05
`define ADSP_CH_STX 7'h02
`define ADSP_CH_ETX 7'h03
`define ADSP_CH_ACK 7'h06
`define ADSP_CH_BS 7'h08
`define ADSP_CH_NAK 7'h15
`define ADSP_CH_ZERO 7'h30
`define ADSP_CH_PLUS 7'h2b
`define ADSP_CH_MINUS 7'h2d
`define ADSP_CH_SPACE 7'h20
`define ADSP_BCC_LIMIT 7'h1f
`define ADSP_BCC_OFFSET 7'h20
`define ADSP_ADDR_CHARS 4'h4
`define ADSP_PARAM_CHARS 4'h4
`define ADSP_DATA_CHARS 4'h5
`define ADSP_HIRES_CHARS 4'h6
`define ADSP_REPLY_LEN 4'hc
`endif

// ==== common/adsp_pkg.sv ====
// Types shared by the drive serial protocol engine
package adsp_pkg;
  typedef struct packed {
    logic valid;
    logic [6:0] data;
  } adsp_char_t;

  typedef struct packed {
    logic req;
    logic [15:0] num;
    logic [15:0] value;
    logic neg;
  } adsp_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_KIND = 4'h2,
    ST_RPAR = 4'h3,
    ST_WDAT = 4'h4,
    ST_WBCC = 4'h5,
    ST_WAIT = 4'h6,
    ST_RLOOK = 4'h7,
    ST_TX = 4'h8,
    ST_FOLLOW = 4'h9,
    ST_SKIP = 4'ha,
    ST_WLOOK = 4'hb
  } adsp_state_t;
endpackage

// ==== hw/adsp_engine.sv ====
// Character level protocol engine of the drive serial link
`timescale 1ns/1ps
`default_nettype none
`include "adsp_regs.svh"
module adsp_engine (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  input wire logic CE_IN,
  // Drive address as two decimal digits
  input wire logic [3:0] ADDR_TENS_IN,
  input wire logic [3:0] ADDR_ONES_IN,
  // Received characters from the UART
  input wire adsp_pkg::adsp_char_t RX_IN,
  // Characters to the UART
  output adsp_pkg::adsp_char_t TX_OUT,
  input wire logic TX_READY_IN,
  // Parameter database lookup
  output logic LOOK_REQ_OUT,
  output logic [15:0] LOOK_NUM_OUT,
  input wire logic LOOK_DONE_IN,
  input wire logic LOOK_FOUND_IN,
  input wire logic LOOK_INRANGE_IN,
  input wire logic LOOK_NEG_IN,
  input wire logic [15:0] LOOK_VALUE_IN,
  input wire logic [15:0] LOOK_NEXT_IN,
  input wire logic [15:0] LOOK_PREV_IN,
  // Parameter write
  output adsp_pkg::adsp_wr_t WR_OUT
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic is_digit(input logic [6:0] c);
    is_digit = (c >= `ADSP_CH_ZERO) && (c <= 7'h39);
  endfunction

  function automatic logic [6:0] bcc_fix(input logic [6:0] x);
    bcc_fix = (x <= `ADSP_BCC_LIMIT) ? x + `ADSP_BCC_OFFSET : x;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  adsp_pkg::adsp_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [15:0] num_r, num_nxt;
  logic [6:0] adr_r [4];
  logic [6:0] adr_nxt [4];
  logic [15:0] val_r, val_nxt;
  logic neg_r, neg_nxt;
  logic [6:0] xor_r, xor_nxt;
  logic bad_r, bad_nxt;
  logic [15:0] nxt_r, nxt_nxt, prv_r, prv_nxt;
  logic [6:0] tb_r [12];
  logic [6:0] tb_nxt [12];
  logic [3:0] tlen_r, tlen_nxt, tix_r, tix_nxt;
  adsp_pkg::adsp_char_t tx_r, tx_nxt;
  logic lreq_r, lreq_nxt;
  adsp_pkg::adsp_wr_t wr_r, wr_nxt;

  logic [6:0] c;
  logic rxv;
  logic [6:0] a1, a0;
  logic addr_ok;
  logic [6:0] rx_xor;
  logic [6:0] rbcc;

  assign c = RX_IN.data;
  assign rxv = RX_IN.valid;
  assign a1 = `ADSP_CH_ZERO | {3'h0, ADDR_TENS_IN};
  assign a0 = `ADSP_CH_ZERO | {3'h0, ADDR_ONES_IN};
  // Own address or all zeros broadcast, each digit doubled
  assign addr_ok = (adr_r[0] == adr_r[1]) && (adr_r[2] == adr_r[3]) &&
    (((adr_r[0] == a1) && (adr_r[2] == a0)) ||
     ((adr_r[0] == `ADSP_CH_ZERO) && (adr_r[2] == `ADSP_CH_ZERO)));
  assign rx_xor = xor_r ^ c;

  // Reply check over parameter, data and ETX
  always_comb begin
    rbcc = 7'h00;
    for (int i = 1; i < 11; i++) begin
      rbcc = rbcc ^ tb_nxt[i];
    end
    rbcc = bcc_fix(rbcc);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    num_nxt = num_r;
    adr_nxt = adr_r;
    val_nxt = val_r;
    neg_nxt = neg_r;
    xor_nxt = xor_r;
    bad_nxt = bad_r;
    nxt_nxt = nxt_r;
    prv_nxt = prv_r;
    tb_nxt = tb_r;
    tlen_nxt = tlen_r;
    tix_nxt = tix_r;
    tx_nxt = tx_r;
    lreq_nxt = 1'b0;
    wr_nxt = wr_r;
    wr_nxt.req = 1'b0;
    if (tx_r.valid && TX_READY_IN) begin
      tx_nxt.valid = 1'b0;
    end
    if (rxv && (c == `ADSP_CH_EOT)) begin
      st_nxt = adsp_pkg::ST_ADDR;
      cnt_nxt = 4'h0;
    end else begin
      unique case (st_r)
        adsp_pkg::ST_IDLE, adsp_pkg::ST_SKIP, adsp_pkg::ST_WAIT: begin
          // Silent until next EOT
        end
        adsp_pkg::ST_ADDR: if (rxv) begin
          adr_nxt[cnt_r[1:0]] = c;
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == `ADSP_ADDR_CHARS - 4'h1) begin
            st_nxt = adsp_pkg::ST_KIND;
          end
        end
        adsp_pkg::ST_KIND: if (!addr_ok) begin
          st_nxt = adsp_pkg::ST_SKIP;
        end else if (rxv) begin
          cnt_nxt = 4'h0;
          num_nxt = 16'h0000;
          val_nxt = 16'h0000;
          neg_nxt = 1'b0;
          bad_nxt = 1'b0;
          xor_nxt = 7'h00;
          if (c == `ADSP_CH_STX) begin
            st_nxt = adsp_pkg::ST_WDAT;
          end else if (is_digit(c)) begin
            num_nxt = {12'h000, c[3:0]};
            cnt_nxt = 4'h1;
            st_nxt = adsp_pkg::ST_RPAR;
          end else begin
            st_nxt = adsp_pkg::ST_SKIP;
          end
        end
        adsp_pkg::ST_RPAR: if (rxv) begin
          if (is_digit(c) && (cnt_r < `ADSP_PARAM_CHARS)) begin
            num_nxt = {num_r[11:0], c[3:0]};
            cnt_nxt = cnt_r + 4'h1;
          end else if ((c == `ADSP_CH_ENQ) && (cnt_r == `ADSP_PARAM_CHARS)) begin
            lreq_nxt = 1'b1;
            st_nxt = adsp_pkg::ST_RLOOK;
          end else begin
            st_nxt = adsp_pkg::ST_SKIP;
          end
        end
        adsp_pkg::ST_WDAT: if (rxv) begin
          xor_nxt = rx_xor;
          cnt_nxt = (cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1;
          if (c == `ADSP_CH_ETX) begin
            st_nxt = adsp_pkg::ST_WBCC;
            // Value must be one to six characters, sign included
            if ((cnt_r < `ADSP_PARAM_CHARS + 4'h1) ||
                (cnt_r > `ADSP_PARAM_CHARS + `ADSP_HIRES_CHARS)) begin
              bad_nxt = 1'b1;
            end
          end else if (cnt_r < `ADSP_PARAM_CHARS) begin
            if (is_digit(c)) num_nxt = {num_r[11:0], c[3:0]};
            else bad_nxt = 1'b1;
          end else if ((cnt_r == `ADSP_PARAM_CHARS) && (c == `ADSP_CH_MINUS)) begin
            neg_nxt = 1'b1;
          end else if ((cnt_r == `ADSP_PARAM_CHARS) &&
                       ((c == `ADSP_CH_PLUS) || (c == `ADSP_CH_SPACE))) begin
          end else if (is_digit(c)) begin
            val_nxt = 16'(val_r * 16'd10) + {12'h000, c[3:0]};
          end else begin
            bad_nxt = 1'b1;
          end
        end
        adsp_pkg::ST_WBCC: if (rxv) begin
          if (bad_r || (c != bcc_fix(xor_r))) begin
            st_nxt = adsp_pkg::ST_WAIT;
            tx_nxt = '{valid: 1'b1, data: `ADSP_CH_NAK};
          end else begin
            lreq_nxt = 1'b1;
            st_nxt = adsp_pkg::ST_WLOOK;
          end
        end
        adsp_pkg::ST_WLOOK: if (LOOK_DONE_IN) begin
          st_nxt = adsp_pkg::ST_WAIT;
          if (LOOK_FOUND_IN && LOOK_INRANGE_IN) begin
            wr_nxt = '{req: 1'b1, num: num_r, value: val_r, neg: neg_r};
            tx_nxt = '{valid: 1'b1, data: `ADSP_CH_ACK};
          end else begin
            tx_nxt = '{valid: 1'b1, data: `ADSP_CH_NAK};
          end
        end
        adsp_pkg::ST_RLOOK: if (LOOK_DONE_IN) begin
          if (!LOOK_FOUND_IN) begin
            tx_nxt = '{valid: 1'b1, data: `ADSP_CH_EOT};
            st_nxt = adsp_pkg::ST_WAIT;
          end else begin
            tb_nxt[0] = `ADSP_CH_STX;
            for (int i = 0; i < 4; i++) begin
              tb_nxt[1 + i] = `ADSP_CH_ZERO | {3'h0, num_r[15 - 4 * i -: 4]};
              tb_nxt[6 + i] = `ADSP_CH_ZERO | {3'h0, LOOK_VALUE_IN[15 - 4 * i -: 4]};
            end
            tb_nxt[5] = LOOK_NEG_IN ? `ADSP_CH_MINUS : `ADSP_CH_PLUS;
            tb_nxt[10] = `ADSP_CH_ETX;
            tb_nxt[11] = rbcc;
            tlen_nxt = `ADSP_REPLY_LEN;
            tix_nxt = 4'h0;
            nxt_nxt = LOOK_NEXT_IN;
            prv_nxt = LOOK_PREV_IN;
            st_nxt = adsp_pkg::ST_TX;
          end
        end
        adsp_pkg::ST_TX: if (!tx_r.valid || TX_READY_IN) begin
          if (tix_r == tlen_r) begin
            st_nxt = adsp_pkg::ST_FOLLOW;
          end else begin
            tx_nxt = '{valid: 1'b1, data: tb_r[tix_r]};
            tix_nxt = tix_r + 4'h1;
          end
        end
        adsp_pkg::ST_FOLLOW: if (rxv) begin
          lreq_nxt = 1'b1;
          st_nxt = adsp_pkg::ST_RLOOK;
          if (c == `ADSP_CH_ACK) num_nxt = nxt_r;
          else if (c == `ADSP_CH_BS) num_nxt = prv_r;
          else if (c != `ADSP_CH_NAK) begin
            lreq_nxt = 1'b0;
            st_nxt = adsp_pkg::ST_SKIP;
          end
        end
        default: st_nxt = adsp_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge MCLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_r <= adsp_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      num_r <= 16'h0000;
      val_r <= 16'h0000;
      neg_r <= 1'b0;
      xor_r <= 7'h00;
      bad_r <= 1'b0;
      nxt_r <= 16'h0000;
      prv_r <= 16'h0000;
      tlen_r <= 4'h0;
      tix_r <= 4'h0;
      tx_r <= '0;
      lreq_r <= 1'b0;
      wr_r <= '0;
      for (int i = 0; i < 4; i++) adr_r[i] <= 7'h00;
      for (int i = 0; i < 12; i++) tb_r[i] <= 7'h00;
    end else if (CE_IN) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      num_r <= num_nxt;
      val_r <= val_nxt;
      neg_r <= neg_nxt;
      xor_r <= xor_nxt;
      bad_r <= bad_nxt;
      nxt_r <= nxt_nxt;
      prv_r <= prv_nxt;
      tlen_r <= tlen_nxt;
      tix_r <= tix_nxt;
      tx_r <= tx_nxt;
      lreq_r <= lreq_nxt;
      wr_r <= wr_nxt;
      adr_r <= adr_nxt;
      tb_r <= tb_nxt;
    end
  end

  assign TX_OUT = tx_r;
  assign LOOK_REQ_OUT = lreq_r;
  assign LOOK_NUM_OUT = num_r;
  assign WR_OUT = wr_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_eot_restart: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (CE_IN && RX_IN.valid && RX_IN.data == `ADSP_CH_EOT) |=> st_r == adsp_pkg::ST_ADDR)
    else $error("EOT did not restart address reception");
  chk_wr_needs_ok: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    $rose(wr_r.req) |-> tx_r.data == `ADSP_CH_ACK)
    else $error("Parameter written without ACK");
  chk_unaddr_quiet: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (st_r == adsp_pkg::ST_SKIP) |=> !$rose(tx_r.valid))
    else $error("Unaddressed drive transmitted");
  chk_bcc_range: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (st_r == adsp_pkg::ST_TX) |-> tb_r[11] > `ADSP_BCC_LIMIT)
    else $error("Reply check character in control range");
  chk_reply_stx: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (st_r == adsp_pkg::ST_TX) |-> tb_r[0] == `ADSP_CH_STX && tb_r[10] == `ADSP_CH_ETX)
    else $error("Reply framing wrong");
  chk_unknown_eot: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (CE_IN && st_r == adsp_pkg::ST_RLOOK && LOOK_DONE_IN && !LOOK_FOUND_IN && !(RX_IN.valid && RX_IN.data == `ADSP_CH_EOT))
    |=> tx_r.valid && tx_r.data == `ADSP_CH_EOT)
    else $error("Unknown parameter not answered with EOT");
  chk_range_nak: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (CE_IN && st_r == adsp_pkg::ST_WLOOK && LOOK_DONE_IN && !LOOK_INRANGE_IN && !RX_IN.valid)
    |=> tx_r.data == `ADSP_CH_NAK && !wr_r.req)
    else $error("Out of range value not refused");
  chk_sign_char: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (st_r == adsp_pkg::ST_TX) |-> (tb_r[5] == `ADSP_CH_PLUS || tb_r[5] == `ADSP_CH_MINUS))
    else $error("Reply sign character wrong");
endmodule
`default_nettype wire

// ==== verification/adsp_db_model.sv ====
// Parameter database and transmit side model facing the protocol engine
`timescale 1ns/1ps
`default_nettype none
module adsp_db_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Slow lookups and a stalling transmitter when high
  input wire logic slow_in,
  // Lookup request
  input wire logic look_req_in,
  input wire logic [15:0] look_num_in,
  // Lookup answer
  output logic look_done_out,
  output logic found_out,
  output logic inrange_out,
  output logic neg_out,
  output logic [15:0] value_out,
  output logic [15:0] next_out,
  output logic [15:0] prev_out,
  // Transmitter acceptance
  output logic tx_ready_out
);
  logic [15:0] num_r;
  logic [3:0] cnt_r;
  logic busy_r;
  logic [2:0] ph_r;
  logic found;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      num_r <= 16'h0000;
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
      ph_r <= 3'h0;
      look_done_out <= 1'b0;
    end else begin
      ph_r <= ph_r + 3'h1;
      look_done_out <= 1'b0;
      if (look_req_in) begin
        num_r <= look_num_in;
        busy_r <= 1'b1;
        cnt_r <= slow_in ? 4'h9 : 4'h0;
      end else if (busy_r) begin
        if (cnt_r == 4'h0) begin
          busy_r <= 1'b0;
          look_done_out <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 4'h1;
        end
      end
    end
  end
  // Answer fields are only good while done is high; otherwise they show garbage
  assign found = num_r inside {16'h0116, 16'h0117, 16'h0118};
  assign found_out = look_done_out ? found : ~found;
  assign inrange_out = look_done_out ? (num_r != 16'h0118) : (num_r == 16'h0118);
  assign neg_out = look_done_out ? num_r[0] : ~num_r[0];
  assign value_out = look_done_out ? 16'h0476 : 16'hfb89;
  assign next_out = look_done_out ? num_r + 16'h0001 : ~num_r;
  assign prev_out = look_done_out ? num_r - 16'h0001 : ~num_r;
  assign tx_ready_out = !slow_in || ph_r[1];
endmodule
`default_nettype wire

// ==== verification/ascii_drive_serial_protocol_tb.sv ====
// Self-checking testbench of the drive serial protocol engine
`timescale 1ns/1ps
`default_nettype none
module ascii_drive_serial_protocol_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic slow = 1'b0;
  logic ce = 1'b1;
  adsp_pkg::adsp_char_t rx = '0;
  adsp_pkg::adsp_char_t tx;
  adsp_pkg::adsp_wr_t wr;
  adsp_pkg::adsp_wr_t wr_last = '0;
  logic tx_ready, look_req, look_done, found, inrange, neg;
  logic [15:0] look_num, value, nxt, prv;
  logic [6:0] got_q[$];
  int num_errors = 0;
  int compares = 0;
  int wr_cnt = 0;
  string msg[12];
  string exp[12];
  // ************
  // Instances
  // ************
  adsp_engine i_adsp_engine (.MCLK_IN(mclk), .RESET_IN(reset), .CE_IN(ce), .ADDR_TENS_IN(4'h1),
    .ADDR_ONES_IN(4'h4), .RX_IN(rx), .TX_OUT(tx), .TX_READY_IN(tx_ready), .LOOK_REQ_OUT(look_req),
    .LOOK_NUM_OUT(look_num), .LOOK_DONE_IN(look_done), .LOOK_FOUND_IN(found), .LOOK_INRANGE_IN(inrange),
    .LOOK_NEG_IN(neg), .LOOK_VALUE_IN(value), .LOOK_NEXT_IN(nxt), .LOOK_PREV_IN(prv), .WR_OUT(wr));
  adsp_db_model i_adsp_db_model (.clk_in(mclk), .rst_in(reset), .slow_in(slow), .look_req_in(look_req),
    .look_num_in(look_num), .look_done_out(look_done), .found_out(found), .inrange_out(inrange),
    .neg_out(neg), .value_out(value), .next_out(nxt), .prev_out(prv), .tx_ready_out(tx_ready));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (tx.valid === 1'b1 && tx_ready === 1'b1) got_q.push_back(tx.data);
    if (wr.req === 1'b1) begin
      wr_last <= wr;
      wr_cnt <= wr_cnt + 1;
    end
  end
  // ************
  // Helpers
  // ************
  function automatic string ch(logic [6:0] v);
    string s;
    s = " ";
    s.putc(0, byte'({1'b0, v}));
    return s;
  endfunction
  function automatic logic [6:0] bcc(string s);
    logic [6:0] x;
    x = 7'h00;
    foreach (s[i]) x = x ^ 7'(s[i]);
    if (x <= 7'h1f) x = x + 7'h20;
    return x;
  endfunction
  function automatic string reply(string num, bit sgn);
    string b;
    b = {num, sgn ? "-" : "+", "0476", "\003"};
    return {"\002", b, ch(bcc(b))};
  endfunction
  function automatic string wmsg(string body, bit bad);
    string b;
    b = {body, "\003"};
    return {"\0041144\002", b, ch(bcc(b) ^ {6'h00, bad})};
  endfunction
  task automatic check(logic [31:0] seen, logic [31:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic send_str(string s);
    got_q.delete();
    foreach (s[k]) begin
      @(negedge mclk);
      rx = {1'b1, 7'(s[k])};
      @(negedge mclk);
      rx = '0;
    end
  endtask
  task automatic expect_str(string e);
    int n;
    n = 0;
    while (got_q.size() < e.len() && n < 400) begin
      @(posedge mclk);
      n++;
    end
    repeat (30) @(posedge mclk);
    check(32'(got_q.size()), 32'(e.len()));
    foreach (e[k]) if (k < got_q.size()) check({25'h0, got_q[k]}, 32'(e[k]));
  endtask
  task automatic close_out();
    $display("Errors %0d comparisons %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ************
  // Tests
  // ************
  initial begin
    #300000;
    num_errors++;
    close_out();
  end
  initial begin
    msg[0] = "\00411440117\005"; exp[0] = reply("0117", 1'b1);
    msg[1] = "\025"; exp[1] = reply("0117", 1'b1);
    msg[2] = "\006"; exp[2] = reply("0118", 1'b0);
    msg[3] = "\010"; exp[3] = reply("0117", 1'b1);
    msg[4] = "\00411441723\005"; exp[4] = "\004";
    msg[5] = "\00400000116\005"; exp[5] = reply("0116", 1'b0);
    msg[6] = "\00422220117\005"; exp[6] = "";
    msg[7] = "\0041144011\00411440117\005"; exp[7] = reply("0117", 1'b1);
    msg[8] = wmsg("0117-476", 1'b0); exp[8] = "\006";
    msg[9] = wmsg("0117-476", 1'b1); exp[9] = "\025";
    msg[10] = wmsg("0117-123456", 1'b0); exp[10] = "\025";
    msg[11] = wmsg("0118+476", 1'b0); exp[11] = "\025";
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    for (int i = 0; i < 12; i++) begin
      slow = i[0];
      send_str(msg[i]);
      expect_str(exp[i]);
    end
    check(32'(wr_cnt), 32'd1);
    check({15'h0, wr_last.num, wr_last.neg}, {15'h0, 16'h0117, 1'b1});
    check({16'h0, wr_last.value}, 32'd476);
    // Clock enable low freezes the engine: a whole read goes unanswered
    @(negedge mclk);
    ce = 1'b0;
    send_str("\00411440117\005");
    expect_str("");
    @(negedge mclk);
    ce = 1'b1;
    // Reset in mid-message, then a clean read
    send_str("\0041144");
    reset = 1'b1;
    @(negedge mclk);
    check({24'h0, tx}, 32'h0);
    check({31'h0, look_req}, 32'h0);
    check({31'h0, wr.req}, 32'h0);
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    send_str("\00411440118\005");
    expect_str(reply("0118", 1'b0));
    close_out();
  end
endmodule
`default_nettype wire
